// [src/nfp_bus_port.sv]
// pin front end of a 16-bit parallel flash: address latch, write latch,
// output/wait enables, reset handling; pins sampled on clk_sys_i, but wp_n and rst_n_i also drive enables combinationally
// Functional notes
// - sync read: latch address at ADV rise/first clock
// - async: latch at ADV rise, else flow through
// - chip select high: outputs and wait tristated
// - drive data only while output enable low
// - reset low: abort automation, ignore writes
// - reset release enters async array read
// - write-protect low: lock-down unlock blocked
// - write-protect high overrides lock-down
// - write latched at first strobe/select rise
// - voltage lockout blocks array changes
// - wait polarity from config bit 10
// - sync read: wait asserted until data valid
// - async reads and writes: wait deasserted
// - data bus returns mode-selected contents
// - reset default: async array, status 0x80
`timescale 1ns/1ps
`include "nfp_map.svh"
module nfp_bus_port import nfp_pkg::*; (
  // clock, enable, reset
  input wire logic clk_sys_i,
  input wire logic clk_en_i,
  input wire logic rst_i,
  // host pins
  input wire logic rst_n_i,
  input wire nfp_pins_t pins_i,
  input wire logic [`NFP_DATA_W-1:0] dq_i,
  output logic [`NFP_DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic wait_o,
  output logic wait_oe_o,
  // core side
  input wire logic prog_voltage_lockout_i,
  input wire logic [`NFP_DATA_W-1:0] read_config_reg_i,
  input wire logic [`NFP_DATA_W-1:0] array_data_i,
  input wire logic array_data_vld_i,
  input wire logic [`NFP_DATA_W-1:0] id_data_i,
  input wire nfp_rdmode_t mode_req_i,
  input wire logic mode_req_vld_i,
  input wire logic [7:0] status_i,
  input wire logic status_vld_i,
  output logic [`NFP_ADDR_W-1:0] addr_o,
  output nfp_wr_t wr_o,
  output logic array_wr_en_o,
  output logic lockdown_en_o,
  output logic core_rst_o
);

  ////////////////////////////////////////////////////////////////////////
  // state and helpers
  nfp_state_s_t cur_ff, nxt_cur;
  logic dev_rst;       // reset pin low or sync reset
  logic sel;           // chip selected
  logic sync_mode;     // burst read mode from config
  logic wait_pol;      // asserted level of wait

  // apply wait polarity to a not-ready flag
  // one place for the polarity so every wait path agrees
  function automatic logic wait_lvl(input logic pol, input logic busy);
    wait_lvl = busy ? pol : ~pol;
  endfunction

  // the reset pin and the system reset load the same state; the pin only while the enable is high
  assign dev_rst = rst_i | ~rst_n_i;
  assign sel = ~pins_i.ce_n;
  assign sync_mode = read_config_reg_i[`NFP_RCR_SYNC_BIT];
  assign wait_pol = read_config_reg_i[`NFP_RCR_WAIT_POL_BIT];

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [`NFP_DATA_W-1:0] rd;
    rd = '0;
    nxt_cur = cur_ff;
    nxt_cur.wr.vld = 1'b0;
    // read data source by mode
    case (cur_ff.mode)
      NFP_RD_STATUS: rd = {8'h00, cur_ff.status};
      NFP_RD_ID: rd = id_data_i;
      NFP_RD_CFG: rd = read_config_reg_i;
      default: rd = array_data_i;
    endcase
    // address latch
    // sync mode: adv_seen marks the capture edge, later edges keep it
    // a strobe held low through standby captures on its first edge, so a
    // sync host pulses addr_valid_n high between accesses
    if (!pins_i.addr_valid_n) begin
      if (sync_mode && cur_ff.adv_seen) begin
        nxt_cur.addr = cur_ff.addr;
      end else begin
        nxt_cur.addr = pins_i.addr;
        nxt_cur.adv_seen = sync_mode;
      end
    end else begin
      nxt_cur.adv_seen = 1'b0;
    end
    // status and read mode loads from the command layer
    if (status_vld_i) begin
      nxt_cur.status = status_i;
    end
    if (mode_req_vld_i) begin
      nxt_cur.mode = mode_req_i;
    end
    // bus state machine
    // pins are sampled levels, so a strobe rise is seen one edge late;
    // data for a write is the word held on the edge before the rise
    case (cur_ff.st)
      NFP_IDLE: begin
        if (sel && !pins_i.we_n && pins_i.oe_n) begin
          nxt_cur.st = NFP_WRITE;
        end else if (sel && !pins_i.oe_n) begin
          nxt_cur.st = NFP_READ;
        end
      end
      NFP_WRITE: begin
        nxt_cur.wdata = dq_i;
        if (!sel || pins_i.we_n) begin
          // first rising edge of strobe or select ends the cycle
          nxt_cur.wr.vld = 1'b1;
          nxt_cur.wr.addr = cur_ff.addr;
          nxt_cur.wr.data = cur_ff.wdata;
          nxt_cur.st = NFP_IDLE;
        end
      end
      NFP_READ: begin
        if (!sel || pins_i.oe_n) begin
          nxt_cur.st = NFP_IDLE;
        end
      end
      default: nxt_cur.st = NFP_IDLE;
    endcase
    // output drivers
    // enables are registered: they follow select and output enable one
    // edge late, and a reset pin clears them on the same edge
    nxt_cur.dq = rd;
    nxt_cur.dq_oe = sel && !pins_i.oe_n && pins_i.we_n;
    nxt_cur.wait_oe = sel && !pins_i.oe_n;
    if (sync_mode && cur_ff.st == NFP_READ
        && cur_ff.mode == NFP_RD_ARRAY) begin
      nxt_cur.wait_v = wait_lvl(wait_pol, ~array_data_vld_i);
    end else begin
      nxt_cur.wait_v = wait_lvl(wait_pol, 1'b0);
    end
    // reset pin: abort, drop writes, back to async array read
    // placed last so it overrides every update above
    if (dev_rst) begin
      nxt_cur = '0;
      nxt_cur.st = NFP_IDLE;
      nxt_cur.mode = NFP_RD_ARRAY;
      nxt_cur.status = `NFP_STATUS_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  // reset is not gated by the enable, so a frozen block still clears;
  // with the enable low every other bit holds its value
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cur_ff <= '0;
      cur_ff.st <= NFP_IDLE;
      cur_ff.mode <= NFP_RD_ARRAY;
      cur_ff.status <= `NFP_STATUS_RST;
    end else if (clk_en_i) begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  // write enable and lock-down are combinational so they act at once
  assign dq_o = cur_ff.dq;
  assign dq_oe_o = cur_ff.dq_oe;
  assign wait_o = cur_ff.wait_v;
  assign wait_oe_o = cur_ff.wait_oe;
  assign addr_o = cur_ff.addr;
  assign wr_o = cur_ff.wr;
  assign array_wr_en_o = ~prog_voltage_lockout_i & ~dev_rst;
  assign lockdown_en_o = ~pins_i.wp_n;
  assign core_rst_o = dev_rst;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // properties sample pins and state at the same edge the logic does
  property p_desel_hiz;
    @(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && pins_i.ce_n) |=> (!dq_oe_o && !wait_oe_o);
  endproperty
  a_desel_hiz: assert property (p_desel_hiz)
    else $error("outputs driven while deselected");

  property p_oe_hiz;
    @(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && pins_i.oe_n) |=> !dq_oe_o && !wait_oe_o;
  endproperty
  a_oe_hiz: assert property (p_oe_hiz)
    else $error("outputs driven with output enable high");

  property p_rst_nowr;
    @(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && !rst_n_i) |=> !wr_o.vld && cur_ff.st == NFP_IDLE;
  endproperty
  a_rst_nowr: assert property (p_rst_nowr)
    else $error("write accepted during reset");

  property p_rst_mode;
    @(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && !rst_n_i) |=> cur_ff.mode == NFP_RD_ARRAY
      && cur_ff.status == `NFP_STATUS_RST;
  endproperty
  a_rst_mode: assert property (p_rst_mode)
    else $error("reset did not restore array read");

  property p_wr_latch;
    @(posedge clk_sys_i) disable iff (rst_i || !rst_n_i)
    (clk_en_i && cur_ff.st == NFP_WRITE && (pins_i.ce_n || pins_i.we_n))
      |=> wr_o.vld && wr_o.data == $past(cur_ff.wdata);
  endproperty
  a_wr_latch: assert property (p_wr_latch)
    else $error("write not latched at strobe rise");

  property p_vpp;
    @(posedge clk_sys_i) prog_voltage_lockout_i |-> !array_wr_en_o;
  endproperty
  a_vpp: assert property (p_vpp)
    else $error("array writable under lockout");

  property p_wait_idle;
    @(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && cur_ff.st == NFP_WRITE) |=>
      wait_o == ~read_config_reg_i[`NFP_RCR_WAIT_POL_BIT];
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("wait asserted in write");

  property p_async_hold;
    @(posedge clk_sys_i) disable iff (rst_i || !rst_n_i)
    (clk_en_i && pins_i.addr_valid_n) |=> addr_o == $past(addr_o);
  endproperty
  a_async_hold: assert property (p_async_hold)
    else $error("address changed while latched");

  property p_wp;
    @(posedge clk_sys_i) lockdown_en_o == ~pins_i.wp_n;
  endproperty
  a_wp: assert property (p_wp)
    else $error("lock-down not following write protect");

  // address capture, wait level, read source and reset pin checks
  property p_sync_hold;
    @(posedge clk_sys_i) disable iff (rst_i || !rst_n_i)
    (clk_en_i && sync_mode && cur_ff.adv_seen && !pins_i.addr_valid_n)
      |=> addr_o == $past(addr_o);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("sync address moved after capture");

  property p_flow;
    @(posedge clk_sys_i) disable iff (rst_i || !rst_n_i)
    (clk_en_i && !sync_mode && !pins_i.addr_valid_n)
      |=> addr_o == $past(pins_i.addr);
  endproperty
  a_flow: assert property (p_flow)
    else $error("address did not flow through");

  property p_wait_sync;
    @(posedge clk_sys_i) disable iff (rst_i || !rst_n_i)
    (clk_en_i && sync_mode && cur_ff.st == NFP_READ
      && cur_ff.mode == NFP_RD_ARRAY && !array_data_vld_i)
      |=> wait_o == $past(wait_pol);
  endproperty
  a_wait_sync: assert property (p_wait_sync)
    else $error("wait not asserted while data not valid");

  property p_cfg_read;
    @(posedge clk_sys_i) disable iff (rst_i || !rst_n_i)
    (clk_en_i && cur_ff.mode == NFP_RD_CFG)
      |=> dq_o == $past(read_config_reg_i);
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("config read returned other data");

  property p_rst_quiet;
    @(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && !rst_n_i) |=> !dq_oe_o && !wait_oe_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs driven while reset pin low");

  // scenario covers
  c_write: cover property (@(posedge clk_sys_i) wr_o.vld);
  c_read: cover property (@(posedge clk_sys_i) dq_oe_o);
  c_sync_wait: cover property (@(posedge clk_sys_i)
    cur_ff.st == NFP_READ && sync_mode);
  c_cfg_read: cover property (@(posedge clk_sys_i)
    cur_ff.mode == NFP_RD_CFG && dq_oe_o);
  c_pin_reset: cover property (@(posedge clk_sys_i) !rst_n_i);
endmodule

// [include/nfp_map.svh]
// constants for the flash pin front end
// assumes inclusion by the package and design files
`ifndef NFP_MAP_SVH
`define NFP_MAP_SVH
`define NFP_ADDR_W 26
`define NFP_DATA_W 16
`define NFP_STATUS_RST 8'h80
`define NFP_RCR_RST 16'hbfcf
`define NFP_RCR_WAIT_POL_BIT 10
`define NFP_RCR_SYNC_BIT 15
`endif

// [include/nfp_pkg.sv]
// types for the flash pin front end
// assumes nfp_map.svh on the include path
`include "nfp_map.svh"
package nfp_pkg;
  // read modes selected by the command layer
  typedef enum logic [3:0] {
    NFP_RD_ARRAY = 4'h1,
    NFP_RD_STATUS = 4'h2,
    NFP_RD_ID = 4'h4,
    NFP_RD_CFG = 4'h8
  } nfp_rdmode_t;
  // bus state machine, one-hot
  typedef enum logic [2:0] {
    NFP_IDLE = 3'h1,
    NFP_WRITE = 3'h2,
    NFP_READ = 3'h4
  } nfp_state_t;
  // pin group from the host
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic addr_valid_n;
    logic wp_n;
    logic [`NFP_ADDR_W-1:0] addr;
  } nfp_pins_t;
  // latched write handed to the command layer
  typedef struct packed {
    logic vld;
    logic [`NFP_ADDR_W-1:0] addr;
    logic [`NFP_DATA_W-1:0] data;
  } nfp_wr_t;
  // all module state
  typedef struct packed {
    nfp_state_t st;
    logic [`NFP_ADDR_W-1:0] addr;
    logic adv_seen;
    logic [`NFP_DATA_W-1:0] wdata;
    nfp_wr_t wr;
    logic [`NFP_DATA_W-1:0] dq;
    logic dq_oe;
    logic wait_v;
    logic wait_oe;
    nfp_rdmode_t mode;
    logic [7:0] status;
  } nfp_state_s_t;
endpackage

// [verification/nfp_host_model.sv]
// host model: drives strobes, address and write data of the flash port
// assumes the bench calls its tasks and that the clock runs all the time
`timescale 1ns/1ps
`include "nfp_map.svh"
module nfp_host_model import nfp_pkg::*; (
  // clock
  input wire logic clk_sys_i,
  // pins toward the device
  output nfp_pins_t pins_o,
  output logic [`NFP_DATA_W-1:0] dq_o
);
  // idle: deselected, address strobe tied low
  initial begin
    pins_o = {1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 26'h0000000};
    dq_o = 16'h0000;
  end
  // set all strobes just after an edge
  task automatic drv(input logic ce, oe, we, adv, wp,
                     input logic [`NFP_ADDR_W-1:0] a);
    @(posedge clk_sys_i);
    #1;
    pins_o = {ce, oe, we, adv, wp, a};
  endtask
  // one write: strobe low two cycles, then deselect
  task automatic wr(input logic [`NFP_ADDR_W-1:0] a,
                    input logic [`NFP_DATA_W-1:0] d);
    dq_o = d;
    drv(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, a);
    @(posedge clk_sys_i);
    drv(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, a);
    drv(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, a);
    // released bus no longer shows the data
    dq_o = ~d;
  endtask
endmodule

// [verification/nfp_bus_port_bench.sv]
// bench for the flash pin front end
// assumes nfp_host_model on the host pins, core inputs driven here
`timescale 1ns/1ps
`include "nfp_map.svh"
module nfp_bus_port_bench import nfp_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic rst_n = 1'b1;
  logic lockout = 1'b0;
  logic [15:0] read_config_reg = 16'h0000;
  logic [15:0] adata = 16'h5aa5;
  logic avld = 1'b1;
  nfp_rdmode_t mreq = NFP_RD_ARRAY;
  logic mvld = 1'b0;
  logic [15:0] idd = 16'h6b2d;
  nfp_pins_t pins;
  logic [15:0] hdq, dq;
  logic dq_oe, wt, wt_oe, awe, lde, crst;
  logic [25:0] addr;
  nfp_wr_t wr;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////
  // the one clock also serves burst reads, so it is always driven
  always #10 clk_sys_i = ~clk_sys_i;
  nfp_host_model u_host (.clk_sys_i(clk_sys_i), .pins_o(pins), .dq_o(hdq));
  nfp_bus_port u_dut (.clk_sys_i(clk_sys_i), .clk_en_i(1'b1), .rst_i(rst_i),
    .rst_n_i(rst_n), .pins_i(pins), .dq_i(hdq), .dq_o(dq), .dq_oe_o(dq_oe),
    .wait_o(wt), .wait_oe_o(wt_oe), .prog_voltage_lockout_i(lockout),
    .read_config_reg_i(read_config_reg), .array_data_i(adata), .array_data_vld_i(avld),
    .id_data_i(idd), .mode_req_i(mreq), .mode_req_vld_i(mvld),
    .status_i(8'h00), .status_vld_i(1'b0), .addr_o(addr), .wr_o(wr),
    .array_wr_en_o(awe), .lockdown_en_o(lde), .core_rst_o(crst));
  ////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // one-cycle read mode request from the command layer
  task automatic setm(input nfp_rdmode_t m);
    mreq = m;
    mvld = 1'b1;
    step(1);
    mvld = 1'b0;
  endtask
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // watch ten cycles for a latched write
  task automatic grab(output logic got, output nfp_wr_t cap);
    got = 1'b0;
    repeat (10) begin
      step(1);
      if (wr.vld === 1'b1) begin
        got = 1'b1;
        cap = wr;
      end
    end
  endtask
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // write latch, then a write while the reset pin is low
  task automatic t_write();
    logic got;
    nfp_wr_t cap;
    fork
      u_host.wr(26'h12a5a5c, 16'hc3a5);
      grab(got, cap);
    join
    chk(got === 1'b1 && cap.data === 16'hc3a5, "write data");
    chk(cap.addr === 26'h12a5a5c, "write address");
    rst_n = 1'b0;
    fork
      u_host.wr(26'h0000011, 16'h1111);
      grab(got, cap);
    join
    chk(got === 1'b0 && crst === 1'b1, "write in reset");
    rst_n = 1'b1;
  endtask
  // async read, output disable, standby, address flow and hold
  task automatic t_read();
    u_host.drv(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 26'h0000abc);
    step(3);
    chk(dq_oe === 1'b1 && dq === 16'h5aa5, "read data");
    chk(wt_oe === 1'b1 && wt === 1'b1, "async wait");
    chk(addr === 26'h0000abc, "address flow");
    u_host.drv(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 26'h0000abc);
    u_host.drv(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 26'h0000def);
    step(2);
    chk(dq_oe === 1'b0 && wt_oe === 1'b0, "output disable");
    chk(addr === 26'h0000abc, "address hold");
    u_host.drv(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 26'h0000def);
    step(3);
    chk(dq_oe === 1'b0 && wt_oe === 1'b0, "standby");
  endtask
  // sync read: address capture and wait level both polarities
  task automatic t_sync();
    read_config_reg = 16'h8400;
    avld = 1'b0;
    // strobe high first so the next low edge is a fresh capture
    u_host.drv(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 26'h0000000);
    u_host.drv(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 26'h0000123);
    u_host.drv(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 26'h0000456);
    step(2);
    chk(addr === 26'h0000123, "sync address");
    chk(wt === 1'b1, "wait busy high");
    avld = 1'b1;
    step(3);
    chk(wt === 1'b0, "wait ready high");
    read_config_reg = 16'h8000;
    step(3);
    chk(wt === 1'b1, "wait ready low");
    avld = 1'b0;
    step(3);
    chk(wt === 1'b0, "wait busy low");
    avld = 1'b1;
    read_config_reg = 16'h0000;
    u_host.drv(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 26'h0000000);
  endtask
  // protection pins, status default, reset pin back to array read
  task automatic t_prot();
    u_host.drv(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 26'h0000000);
    step(1);
    chk(lde === 1'b1, "lock-down on");
    u_host.drv(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 26'h0000000);
    lockout = 1'b1;
    step(1);
    chk(lde === 1'b0 && awe === 1'b0, "override, lockout");
    lockout = 1'b0;
    setm(NFP_RD_STATUS);
    u_host.drv(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 26'h0000000);
    step(3);
    chk(dq === 16'h0080, "status default");
    // configuration and protection contents on the same read
    read_config_reg = 16'h0123;
    setm(NFP_RD_CFG);
    step(2);
    chk(dq === 16'h0123, "config read");
    setm(NFP_RD_ID);
    step(2);
    chk(dq === idd, "protection read");
    read_config_reg = 16'h0000;
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    step(4);
    chk(dq === 16'h5aa5, "array after reset");
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    step(2);
    rst_i = 1'b0;
    step(1);
    chk(dq_oe === 1'b0 && wt_oe === 1'b0, "reset outputs");
    chk(awe === 1'b1 && crst === 1'b0, "reset enables");
    t_write();
    t_read();
    t_sync();
    t_prot();
    summarize();
  end
endmodule
